// ===== strap_pkg.sv
// constants and carrier types for the reset strap pin function select block
// Function
// R1 - Numerics mode is entered when the reset output is seen looped back on the wait/busy input during reset.
// R2 - Without that loop-back the block comes up in regular operation with no coprocessor interface.
// R3 - In numerics mode three of the four midrange select pins become coprocessor handshake pins.
// R4 - In regular operation all four midrange select pins stay chip selects.
// R5 - Processor and coprocessor exchange data and control only through four dedicated port addresses.
// R6 - Test equipment selects pin-float test mode by holding both memory selects low while reset input is active.
// R7 - During reset the block holds both memory select pins weakly high.
// R8 - In pin-float test mode every output and bidirectional pin is high impedance; reset_output has no enable and stays driven.
// R9 - Outside logic may build a transmit/receive direction signal by latching bus status bit 1.
// R10 - The muxed address/data pins float while bus hold is acknowledged.
// R11 - The muxed address/data pins float while reset is active.
// R12 - The muxed address/data pins keep their state during powerdown.
// R13 - The wait/busy input is sampled during reset to choose numerics mode.
// R14 - Wait/busy gates the wait instruction in regular operation and reports coprocessor activity in numerics mode.
// R15 - The modes chosen at reset stay latched until the reset input is asserted again.
package strap_pkg;

   localparam int          MIDRANGE_W      = 4;
   localparam int          AD_W            = 16;
   // pins of the midrange group that turn into handshake lines
   localparam logic [3:0]  HANDSHAKE_MASK  = 4'hb;
   // base of the four coprocessor port addresses, a 16-bit I/O word
   localparam logic [15:0] COPROC_IO_BASE  = 16'h00f8;
   localparam logic [15:0] COPROC_IO_MASK  = 16'hfff8;
   localparam logic        NUMERICS_RST    = 1'b0;
   localparam logic        FLOAT_RST       = 1'b0;

   typedef enum {ST_RESET, ST_RUN} phase_type;

   typedef struct packed {
      logic [AD_W-1:0] data;
      logic            oe;
   } ad_drive_type;

endpackage

// ===== reset_strap_pin_function_select.sv
// reset strap capture and pin function steering for the coprocessor and float test modes
`timescale 1ns/1ns
module reset_strap_pin_function_select
   import strap_pkg::*;
(
   // clock and reset
   input  wire logic                  clk,
   input  wire logic                  arst_n,
   // reset input pin, active low, synchronous to clk
   input  wire logic                  reset_input_n,
   // core side controls
   input  wire logic                  hold_ack,
   input  wire logic                  powerdown,
   input  wire ad_drive_type          core_ad,
   input  wire logic [MIDRANGE_W-1:0] core_midrange_select_n,
   input  wire logic [MIDRANGE_W-1:0] core_handshake,
   input  wire logic                  core_upper_select_n,
   input  wire logic                  core_lower_select_n,
   input  wire logic                  core_io_cycle,
   input  wire logic [15:0]           core_io_addr,
   // strap pins as seen at their inputs
   input  wire logic                  wait_busy_in,
   input  wire logic                  upper_memory_select_in,
   input  wire logic                  lower_memory_select_in,
   // pins
   output logic                       reset_output,
   output logic [AD_W-1:0]            muxed_addr_data_bus_o,
   output logic                       muxed_addr_data_bus_oe,
   output logic [MIDRANGE_W-1:0]      midrange_select_o,
   output logic [MIDRANGE_W-1:0]      midrange_select_oe,
   output logic                       upper_memory_select_o,
   output logic                       upper_memory_select_oe,
   output logic                       upper_memory_select_pullup,
   output logic                       lower_memory_select_o,
   output logic                       lower_memory_select_oe,
   output logic                       lower_memory_select_pullup,
   // mode status toward the core
   output logic                       numerics_mode,
   output logic                       pin_float_test_mode,
   output logic                       test_wait_release,
   output logic                       coproc_busy,
   output logic                       coproc_port_hit
);

   // ******************************************
   // reset phase and strap capture
   // ******************************************
   phase_type   phase_ff;
   logic        numerics_ff;
   logic        float_ff;
   logic [AD_W-1:0] ad_hold_ff;
   logic        ad_oe_hold_ff;
   logic        in_reset;

   assign in_reset = ~reset_input_n;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         phase_ff <= ST_RESET;
      end else begin
         case (phase_ff)
            ST_RESET: begin
               if (!in_reset) begin
                  phase_ff <= ST_RUN;
               end
            end
            ST_RUN: begin
               if (in_reset) begin
                  phase_ff <= ST_RESET;
               end
            end
            default: begin
               phase_ff <= ST_RESET;
            end
         endcase
      end
   end

   // straps follow the pins for as long as reset is held, so the last
   // sample before release wins; frozen while running
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         numerics_ff <= NUMERICS_RST;
      end else if (in_reset) begin
         numerics_ff <= wait_busy_in;  // [R1] [R2] [R13] [R15]
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         float_ff <= FLOAT_RST;
      end else if (in_reset) begin
         float_ff <= ~upper_memory_select_in & ~lower_memory_select_in;  // [R6] [R15]
      end
   end

   assign numerics_mode       = numerics_ff;
   assign pin_float_test_mode = float_ff;

   // ******************************************
   // muxed bus state kept through powerdown
   // ******************************************
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ad_hold_ff    <= '0;
         ad_oe_hold_ff <= 1'b0;
      end else if (!powerdown) begin
         ad_hold_ff    <= core_ad.data;
         // hold and reset gate the enable at the pins in the same cycle, not here
         ad_oe_hold_ff <= core_ad.oe;  // [R12]
      end
   end

   // ******************************************
   // pin steering
   // ******************************************
   logic float_all;

   assign float_all    = float_ff & ~in_reset;
   assign reset_output = in_reset | (phase_ff == ST_RESET);

   // data from flops; powerdown freezes both value and enable
   assign muxed_addr_data_bus_o  = ad_hold_ff;  // [R12]
   assign muxed_addr_data_bus_oe = ad_oe_hold_ff & ~in_reset & ~hold_ack
                                   & ~float_all;  // [R10] [R11] [R8]

   always_comb begin
      for (int i = 0; i < MIDRANGE_W; i++) begin
         if (numerics_ff && HANDSHAKE_MASK[i]) begin
            midrange_select_o[i] = core_handshake[i];  // [R3]
         end else begin
            midrange_select_o[i] = core_midrange_select_n[i];  // [R4]
         end
      end
      midrange_select_oe = {MIDRANGE_W{~float_all}};  // [R8]
   end

   // weak pull-up only in reset; strong drive only after release
   assign upper_memory_select_pullup = in_reset;  // [R7]
   assign lower_memory_select_pullup = in_reset;  // [R7]
   assign upper_memory_select_o      = core_upper_select_n;
   assign lower_memory_select_o      = core_lower_select_n;
   assign upper_memory_select_oe     = ~in_reset & ~float_all;  // [R8]
   assign lower_memory_select_oe     = ~in_reset & ~float_all;  // [R8]

   // ******************************************
   // wait/busy meaning and coprocessor ports
   // ******************************************
   // pin is active low in both roles
   assign test_wait_release = ~numerics_ff & ~wait_busy_in & ~in_reset;  // [R14]
   assign coproc_busy       = numerics_ff & ~wait_busy_in & ~in_reset;  // [R14]
   // only the four word ports from the base up reach the coprocessor
   assign coproc_port_hit   = numerics_ff & core_io_cycle & ~in_reset
                              & ((core_io_addr & COPROC_IO_MASK) == COPROC_IO_BASE)
                              & ~core_io_addr[0];  // [R5]

   // ******************************************
   // checks
   // ******************************************
   chk_reset_floats_bus: assert property (  // [R11]
      @(posedge clk) disable iff (!arst_n)
      in_reset |-> !muxed_addr_data_bus_oe && reset_output)
      else $error("bus driven during reset");

   chk_hold_floats_bus: assert property (  // [R10]
      @(posedge clk) disable iff (!arst_n)
      hold_ack |-> !muxed_addr_data_bus_oe)
      else $error("bus driven during hold");

   chk_powerdown_keeps_bus: assert property (  // [R12]
      @(posedge clk) disable iff (!arst_n)
      powerdown && $past(powerdown) && !in_reset && !hold_ack && !float_all
      |-> $stable(muxed_addr_data_bus_o))
      else $error("bus changed in powerdown");

   chk_numerics_latched: assert property (  // [R1]
      @(posedge clk) disable iff (!arst_n)
      in_reset ##1 !in_reset |-> numerics_mode == $past(wait_busy_in))
      else $error("numerics strap not captured");

   chk_mode_held_run: assert property (  // [R15]
      @(posedge clk) disable iff (!arst_n)
      !in_reset && !$past(in_reset) |-> $stable(numerics_mode) && $stable(pin_float_test_mode))
      else $error("mode changed outside reset");

   chk_float_all_pins: assert property (  // [R8]
      @(posedge clk) disable iff (!arst_n)
      pin_float_test_mode && !in_reset
      |-> midrange_select_oe == '0 && !upper_memory_select_oe && !lower_memory_select_oe
          && !muxed_addr_data_bus_oe)
      else $error("pin driven in float test mode");

   chk_handshake_swap: assert property (  // [R3]
      @(posedge clk) disable iff (!arst_n)
      numerics_mode |-> midrange_select_o[0] == core_handshake[0]
                        && midrange_select_o[2] == core_midrange_select_n[2])
      else $error("handshake pins not steered");

   chk_regular_selects: assert property (  // [R4]
      @(posedge clk) disable iff (!arst_n)
      !numerics_mode |-> midrange_select_o == core_midrange_select_n && !coproc_port_hit)
      else $error("selects lost in regular mode");

   chk_pullup_reset: assert property (  // [R7]
      @(posedge clk) disable iff (!arst_n)
      in_reset |-> upper_memory_select_pullup && lower_memory_select_pullup
                   && !upper_memory_select_oe)
      else $error("memory selects not held weakly high");

   chk_busy_role: assert property (  // [R14]
      @(posedge clk) disable iff (!arst_n)
      !in_reset && !wait_busy_in |-> test_wait_release != coproc_busy)
      else $error("wait/busy role wrong");

   chk_port_hit_range: assert property (  // [R5]
      @(posedge clk) disable iff (!arst_n)
      coproc_port_hit |-> numerics_mode && core_io_cycle && !core_io_addr[0]
                          && ((core_io_addr & COPROC_IO_MASK) == COPROC_IO_BASE))
      else $error("coprocessor port outside its four addresses");

   chk_regular_no_busy: assert property (  // [R2]
      @(posedge clk) disable iff (!arst_n)
      !numerics_mode |-> !coproc_busy && !coproc_port_hit)
      else $error("coprocessor role seen in regular mode");

   chk_float_latched: assert property (  // [R6]
      @(posedge clk) disable iff (!arst_n)
      in_reset ##1 !in_reset
      |-> pin_float_test_mode == $past(!upper_memory_select_in && !lower_memory_select_in))
      else $error("float strap not captured");

   chk_reset_out_drops: assert property (  // [R13]
      @(posedge clk) disable iff (!arst_n)
      !in_reset && !$past(in_reset) && phase_ff == ST_RUN |-> !reset_output)
      else $error("reset output stuck after release");

endmodule

// ===== strap_partner.sv
// far-side model: coprocessor loop-back and board test equipment on the memory selects
`timescale 1ns/1ns
module strap_partner (
   // clock
   input  wire logic clk,
   // scenario controls
   input  wire logic pres,
   input  wire logic freq,
   input  wire logic busy,
   // device pins
   input  wire logic ro,
   input  wire logic u_o,
   input  wire logic u_oe,
   input  wire logic u_pu,
   input  wire logic l_o,
   input  wire logic l_oe,
   input  wire logic l_pu,
   output logic      wb,
   output logic      u_in,
   output logic      l_in
);
   logic u_last_ff = 1'b0;
   logic l_last_ff = 1'b0;
   // coprocessor ties reset to wait/busy; a bare board reads low there during reset
   assign wb = pres ? (ro | busy) : (~ro & busy);
   // tester pulls low only while reset is active; undriven, unpulled lines toggle
   assign u_in = u_oe ? u_o : (freq & ro) ? 1'b0 : u_pu ? 1'b1 : ~u_last_ff;
   assign l_in = l_oe ? l_o : (freq & ro) ? 1'b0 : l_pu ? 1'b1 : ~l_last_ff;
   always_ff @(posedge clk) begin
      u_last_ff <= u_in;
      l_last_ff <= l_in;
   end
endmodule

// ===== tb_reset_strap_pin_function_select.sv
// self-checking bench for the reset strap pin function select block
`timescale 1ns/1ns
module tb_reset_strap_pin_function_select;
   import strap_pkg::*;
   typedef struct packed {
      logic ro, rin, num, flt, oe, hit, busy, rel;
      logic [15:0] d;
      logic [3:0]  ms;
      logic [1:0]  us;
   } exp_type;
   logic clk = 0, arst_n = 0, reset_input_n = 0, hold_ack = 0, powerdown = 0;
   logic core_upper_select_n = 1, core_lower_select_n = 1, core_io_cycle = 0;
   logic [3:0] core_midrange_select_n = 0, core_handshake = 0;
   logic [15:0] core_io_addr = 0;
   ad_drive_type core_ad = '0;
   logic wait_busy_in, upper_memory_select_in, lower_memory_select_in, reset_output;
   logic muxed_addr_data_bus_oe, upper_memory_select_o, upper_memory_select_oe;
   logic upper_memory_select_pullup, lower_memory_select_o, lower_memory_select_oe;
   logic lower_memory_select_pullup, numerics_mode, pin_float_test_mode;
   logic test_wait_release, coproc_busy, coproc_port_hit;
   logic [15:0] muxed_addr_data_bus_o, m_d;
   logic [3:0] midrange_select_o, midrange_select_oe;
   logic present = 0, float_req = 0, busy_drv = 0, m_oe = 0, rin_prev, exp_num, exp_flt;
   int fail_count = 0, checks_done = 0;
   exp_type exp_q[$];
   event chk_ev;

   reset_strap_pin_function_select i_dut (.*);
   strap_partner i_far (.clk(clk), .pres(present), .freq(float_req), .busy(busy_drv),
      .ro(reset_output), .u_o(upper_memory_select_o), .u_oe(upper_memory_select_oe),
      .u_pu(upper_memory_select_pullup), .l_o(lower_memory_select_o),
      .l_oe(lower_memory_select_oe), .l_pu(lower_memory_select_pullup),
      .wb(wait_busy_in), .u_in(upper_memory_select_in), .l_in(lower_memory_select_in));

   always #5 clk = ~clk;

   // ****
   // stimulus: one random cycle, expectation noted before the outputs are looked at
   // ****
   task cyc(input logic rin);
      exp_type e;
      logic wb;
      begin
         @(negedge clk);
         // the bus flop took the last drive unless powerdown froze it
         if (!powerdown) {m_oe, m_d} = {core_ad.oe, core_ad.data};
         rin_prev = reset_input_n;
         reset_input_n = rin;
         {hold_ack, powerdown, core_io_cycle, busy_drv} = 4'($urandom);
         {core_upper_select_n, core_lower_select_n} = 2'($urandom);
         core_ad = ad_drive_type'(17'($urandom));
         {core_midrange_select_n, core_handshake} = 8'($urandom);
         core_io_addr = 16'h00f4 + 16'($urandom % 16);
         e.ro = !rin || !rin_prev;
         wb = present ? (e.ro | busy_drv) : (!e.ro & busy_drv);
         {e.rin, e.num, e.flt, e.d} = {rin, exp_num, exp_flt, m_d};
         e.oe = m_oe & !hold_ack & rin & !exp_flt;
         e.ms = exp_num ? (core_handshake & HANDSHAKE_MASK)
                | (core_midrange_select_n & ~HANDSHAKE_MASK) : core_midrange_select_n;
         e.hit = exp_num & core_io_cycle
                 & ((core_io_addr & COPROC_IO_MASK) == COPROC_IO_BASE) & !core_io_addr[0];
         // busy is active low, like the wait release
         e.busy = exp_num & !wb;
         e.rel = !exp_num & !wb;
         e.us = {core_upper_select_n, core_lower_select_n};
         exp_q.push_back(e);
         -> chk_ev;
      end
   endtask

   // straps move after release to show the latched modes ignore them
   task boot(input logic p, input logic f);
      begin
         {present, float_req} = {p, f};
         repeat (4) cyc(1'b0);
         {exp_num, exp_flt} = {p, f};
         repeat (30) cyc(1'b1);
         {present, float_req} = {~p, ~f};
         repeat (10) cyc(1'b1);
      end
   endtask

   // ****
   // checking
   // ****
   task check(input logic [15:0] seen, input logic [15:0] want);
      begin
         checks_done++;
         if (seen !== want) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, want);
         end
      end
   endtask

   always @(chk_ev) begin
      exp_type e;
      #1;
      e = exp_q.pop_front();
      check(reset_output, e.ro);
      check(muxed_addr_data_bus_oe, e.oe);
      if (e.oe) check(muxed_addr_data_bus_o, e.d);
      if (!e.rin) check({upper_memory_select_pullup, lower_memory_select_pullup}, 2'b11);
      if (e.flt || !e.rin) check({upper_memory_select_oe, lower_memory_select_oe}, 2'b00);
      if (!e.flt && e.rin) check({upper_memory_select_oe, lower_memory_select_oe}, 2'b11);
      if (!e.flt && e.rin) check({upper_memory_select_o, lower_memory_select_o}, e.us);
      if (!e.ro) begin
         check(numerics_mode, e.num);
         check(pin_float_test_mode, e.flt);
         check(coproc_port_hit, e.hit);
         check({coproc_busy, test_wait_release}, {e.busy, e.rel});
         if (e.flt) check(midrange_select_oe, 4'h0);
         else begin
            check(midrange_select_o, e.ms);
            check(midrange_select_oe, 4'hf);
         end
      end
   end

   task results;
      begin
         $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
         if (fail_count == 0 && checks_done > 0) $display("Simulation passed");
         else $display("Simulation failed");
         $finish;
      end
   endtask

   initial begin
      void'($urandom(32'h21958083));
      repeat (12) @(negedge clk);
      arst_n = 1;
      boot(1'b0, 1'b0);
      boot(1'b1, 1'b0);
      boot(1'b0, 1'b1);
      boot(1'b1, 1'b1);
      results();
   end

   // about 200 cycles are needed; ten times that means a hang
   initial begin
      #20000;
      fail_count++;
      results();
   end
endmodule
